/* File: fww_pkg.sv */
// Constants for the fail-safe window watchdog: register map, field layout, reset values, timing.
// Assumes a 125 MHz clock and 16-bit register data on a plain strobe bus.
package fww_pkg;
	// ==========================================================
	// Register bus
	localparam int         ADDR_W         = 8;
	localparam int         DATA_W         = 16;
	localparam logic [7:0] REG_STATUS     = 8'h00;
	localparam logic [7:0] REG_SAFETY_IO  = 8'h04;
	localparam logic [7:0] REG_WINDOW     = 8'h08;
	localparam logic [7:0] REG_SEED       = 8'h0C;
	localparam logic [7:0] REG_ANSWER     = 8'h10;
	localparam logic [7:0] REG_WDCFG      = 8'h14;
	localparam logic [7:0] REG_WDCFG_NOT  = 8'h18;
	// ==========================================================
	// Field positions
	localparam int SAFE_GOTO_BIT  = 0;
	localparam int SAFE_CHAL_BIT  = 1;
	localparam int WIN_PER_LSB    = 0;
	localparam int WIN_DUTY_LSB   = 4;
	localparam int CFG_ERRL_LSB   = 0;
	localparam int CFG_RFRL_LSB   = 2;
	localparam int CFG_ERRC_LSB   = 8;
	localparam int CFG_RFRC_LSB   = 12;
	localparam int ST_INIT_BIT    = 0;
	localparam int ST_CORR_BIT    = 1;
	localparam int ST_DIS_BIT     = 2;
	localparam int ST_ERRC_LSB    = 4;
	localparam int ST_RFRC_LSB    = 8;
	// ==========================================================
	// Reset values
	localparam logic [3:0]  PERIOD_RST   = 4'h3;
	localparam logic [2:0]  DUTY_RST     = 3'h2;
	localparam logic [15:0] SEED_RST     = 16'h5AB2;
	localparam logic [3:0]  WDCFG_RST    = 4'h1;
	localparam logic [15:0] SEED_ZERO    = 16'h0000;
	localparam logic [15:0] SEED_ONES    = 16'hFFFF;
	localparam logic [15:0] LFSR_TAPS    = 16'hB400;
	// ==========================================================
	// Timing
	localparam int CLOCK_KHZ     = 125000;
	localparam int MS_CYCLES     = CLOCK_KHZ * 1;
	localparam int INIT_MS0      = 256;
	localparam int INIT_MS1      = 512;
	localparam int INIT_MS2      = 1024;
	localparam int INIT_MS3      = 2048;
	localparam int DUTY_SHIFT    = 4;
	typedef enum logic {FWW_INIT, FWW_NORMAL} fww_state_t;
endpackage : fww_pkg

/* File: fww_watchdog.sv */
// Fail-safe window watchdog with protected initialization phase and refresh/error counters.
// Assumes the controller writes registers over a plain strobe bus on clock_i; the reset
// output level arrives from another domain, the timeout select is a static fuse value.
//
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
module fww_watchdog
	import fww_pkg::*;
#(
	parameter int CYCLES_PER_MS = fww_pkg::MS_CYCLES
)
(
	// Clock and reset.
	input  wire logic                        clock_i,
	input  wire logic                        reset_n_i,
	// Device reset output level and fuse settings.
	input  wire logic                        reset_output_n_i,
	input  wire logic [1:0]                  init_timeout_select_i,
	// Register bus.
	input  wire logic [fww_pkg::ADDR_W-1:0]  addr_i,
	input  wire logic [fww_pkg::DATA_W-1:0]  wr_data_i,
	input  wire logic                        wr_i,
	input  wire logic                        rd_i,
	output logic      [fww_pkg::DATA_W-1:0]  rd_data_o,
	// Status and events.
	output logic                             init_phase_o,
	output logic                             config_mismatch_flag_o,
	output logic                             err_at_limit_o,
	output logic                             refresh_good_o,
	output logic                             refresh_bad_o,
	output logic                             fault_decrement_o,
	output logic                             comm_error_o
);
	import fww_pkg::*;

	// ==========================================================
	// Decoding tables
	function automatic logic [10:0] period_ms(input logic [3:0] code);
		logic [10:0] ms;
		ms = 11'h000;
		unique case (code)
			4'h0: ms = 11'h000;
			4'h1: ms = 11'h001;
			4'h2: ms = 11'h002;
			4'h3: ms = 11'h003;
			4'h4: ms = 11'h004;
			4'h5: ms = 11'h006;
			4'h6: ms = 11'h008;
			4'h7: ms = 11'h00C;
			4'h8: ms = 11'h010;
			4'h9: ms = 11'h018;
			4'hA: ms = 11'h020;
			4'hB: ms = 11'h040;
			4'hC: ms = 11'h080;
			4'hD: ms = 11'h100;
			4'hE: ms = 11'h200;
			4'hF: ms = 11'h400;
		endcase
		return ms;
	endfunction : period_ms

	// Closed share of the period in sixteenths.
	function automatic logic [3:0] duty_16(input logic [2:0] code);
		unique case (code)
			3'h0:    return 4'h5;
			3'h1:    return 4'h6;
			3'h3:    return 4'hA;
			3'h4:    return 4'hB;
			default: return 4'h8;
		endcase
	endfunction : duty_16

	function automatic logic [3:0] err_ceiling(input logic [1:0] code);
		unique case (code)
			2'h0: return 4'h8;
			2'h1: return 4'h6;
			2'h2: return 4'h4;
			2'h3: return 4'h2;
		endcase
	endfunction : err_ceiling

	function automatic logic [2:0] rfr_ceiling(input logic [1:0] code);
		unique case (code)
			2'h0: return 3'h6;
			2'h1: return 3'h4;
			2'h2: return 3'h2;
			2'h3: return 3'h1;
		endcase
	endfunction : rfr_ceiling

	// ==========================================================
	// Declarations
	fww_state_t  state_reg, state_next;
	logic        rsto_s1_reg, rsto_s2_reg, rsto_s3_reg, released_reg;
	logic [3:0]  period_reg, act_period_reg;
	logic [2:0]  duty_reg, act_duty_reg;
	logic        disabled_reg, chal_reg;
	logic [15:0] seed_reg;
	logic [3:0]  wdcfg_reg, wdcfg_not_reg;
	logic [3:0]  err_reg;
	logic [2:0]  rfr_reg;
	logic [31:0] win_cnt_reg;
	logic [31:0] period_len, closed_len, init_len;
	logic [15:0] expected;
	logic        ans_wr, correct, in_open, good_ev, bad_ev, goto_ev;
	logic [3:0]  err_lim;
	logic [2:0]  rfr_lim;
	logic        pair_bad;
	logic [4:0]  err_sum;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);

	// ==========================================================
	// Reset output synchroniser; a level change counts once stages two and three agree.
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rsto_s1_reg  <= 1'b0;
			rsto_s2_reg  <= 1'b0;
			rsto_s3_reg  <= 1'b0;
			released_reg <= 1'b0;
		end
		else
		begin
			rsto_s1_reg <= reset_output_n_i;
			rsto_s2_reg <= rsto_s1_reg;
			rsto_s3_reg <= rsto_s2_reg;
			if (rsto_s2_reg == rsto_s3_reg)
				released_reg <= rsto_s3_reg;
		end
	end

	// ==========================================================
	// Window timing and refresh judgement.
	assign period_len = 32'(period_ms(act_period_reg)) * 32'(CYCLES_PER_MS);
	assign closed_len = (period_len * 32'(duty_16(act_duty_reg))) >> DUTY_SHIFT;
	assign expected   = chal_reg ? ~seed_reg : seed_reg;
	assign ans_wr     = wr_i && (addr_i == REG_ANSWER);
	assign correct    = (wr_data_i == expected);
	assign in_open    = (win_cnt_reg >= closed_len);
	assign goto_ev    = wr_i && (addr_i == REG_SAFETY_IO) && wr_data_i[SAFE_GOTO_BIT]
	                    && (state_reg == FWW_NORMAL);
	assign err_lim    = err_ceiling(wdcfg_reg[CFG_ERRL_LSB +: 2]);
	assign rfr_lim    = rfr_ceiling(wdcfg_reg[CFG_RFRL_LSB +: 2]);
	assign pair_bad   = ((wdcfg_reg ^ wdcfg_not_reg) != 4'hF);
	assign err_sum    = 5'(err_reg) + 5'h02;

	always_comb
	begin
		unique case (init_timeout_select_i)
			2'h0: init_len = 32'(INIT_MS0) * 32'(CYCLES_PER_MS);
			2'h1: init_len = 32'(INIT_MS1) * 32'(CYCLES_PER_MS);
			2'h2: init_len = 32'(INIT_MS2) * 32'(CYCLES_PER_MS);
			2'h3: init_len = 32'(INIT_MS3) * 32'(CYCLES_PER_MS);
		endcase
	end

	always_comb
	begin
		good_ev    = 1'b0;
		bad_ev     = 1'b0;
		state_next = state_reg;
		if (!released_reg)
			state_next = FWW_INIT;
		else if (state_reg == FWW_INIT)
		begin
			good_ev = ans_wr && correct;
			bad_ev  = (ans_wr && !correct) || (!ans_wr && win_cnt_reg >= init_len - 32'h1);
			if (good_ev)
				state_next = FWW_NORMAL;
		end
		else if (goto_ev)
			state_next = FWW_INIT;
		else if (!disabled_reg)
		begin
			good_ev = ans_wr && correct && in_open;
			bad_ev  = (ans_wr && !(correct && in_open)) || (!ans_wr && win_cnt_reg >= period_len - 32'h1);
		end
	end

	// ==========================================================
	// State and window counter.
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			state_reg   <= FWW_INIT;
			win_cnt_reg <= 32'h0;
		end
		else
		begin
			state_reg <= state_next;
			if (!released_reg || good_ev || bad_ev || goto_ev || (state_reg == FWW_NORMAL && disabled_reg))
				win_cnt_reg <= 32'h0;
			else
				win_cnt_reg <= win_cnt_reg + 32'h1;
		end
	end

	// Active window settings are taken on each refresh; disable only when initialization closes.
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			act_period_reg <= PERIOD_RST;
			act_duty_reg   <= DUTY_RST;
			disabled_reg   <= 1'b0;
		end
		else if (good_ev || bad_ev)
		begin
			act_duty_reg <= duty_reg;
			if (period_reg != 4'h0)
				act_period_reg <= period_reg;
			if (state_reg == FWW_INIT && good_ev)
				disabled_reg <= (period_reg == 4'h0);
		end
		else if (state_next == FWW_INIT)
			disabled_reg <= 1'b0;
	end

	// ==========================================================
	// Software-written configuration.
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			period_reg    <= PERIOD_RST;
			duty_reg      <= DUTY_RST;
			chal_reg      <= 1'b0;
			wdcfg_reg     <= WDCFG_RST;
			wdcfg_not_reg <= ~WDCFG_RST;
		end
		else if (wr_i)
		begin
			if (addr_i == REG_WINDOW)
			begin
				duty_reg <= wr_data_i[WIN_DUTY_LSB +: 3];
				if (state_reg == FWW_INIT || wr_data_i[WIN_PER_LSB +: 4] != 4'h0)
					period_reg <= wr_data_i[WIN_PER_LSB +: 4];
			end
			if (state_reg == FWW_INIT)
			begin
				if (addr_i == REG_SAFETY_IO)
					chal_reg <= wr_data_i[SAFE_CHAL_BIT];
				if (addr_i == REG_WDCFG)
					wdcfg_reg <= wr_data_i[3:0];
				if (addr_i == REG_WDCFG_NOT)
					wdcfg_not_reg <= wr_data_i[3:0];
			end
		end
	end

	// Seed in simple mode, LFSR word in challenger mode.
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			seed_reg     <= SEED_RST;
			comm_error_o <= 1'b0;
		end
		else
		begin
			comm_error_o <= 1'b0;
			if (wr_i && addr_i == REG_SEED)
			begin
				if (!chal_reg && (wr_data_i == SEED_ZERO || wr_data_i == SEED_ONES))
					comm_error_o <= 1'b1;
				else if (!chal_reg || state_reg == FWW_INIT)
					seed_reg <= wr_data_i;
			end
			else if (chal_reg && good_ev)
				seed_reg <= {seed_reg[14:0], ^(seed_reg & LFSR_TAPS)};
		end
	end

	// ==========================================================
	// Error and refresh counters.
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			err_reg           <= 4'h0;
			rfr_reg           <= 3'h0;
			fault_decrement_o <= 1'b0;
		end
		else
		begin
			fault_decrement_o <= 1'b0;
			if (bad_ev)
			begin
				err_reg <= (err_sum > 5'(err_lim)) ? err_lim : err_sum[3:0];
				rfr_reg <= 3'h0;
			end
			else if (good_ev)
			begin
				if (err_reg != 4'h0)
					err_reg <= err_reg - 4'h1;
				if (rfr_reg >= rfr_lim)
				begin
					rfr_reg           <= 3'h0;
					fault_decrement_o <= 1'b1;
				end
				else
					rfr_reg <= rfr_reg + 3'h1;
			end
		end
	end

	// ==========================================================
	// Outputs and register reads.
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			init_phase_o           <= 1'b1;
			config_mismatch_flag_o <= 1'b0;
			err_at_limit_o         <= 1'b0;
			refresh_good_o         <= 1'b0;
			refresh_bad_o          <= 1'b0;
		end
		else
		begin
			init_phase_o           <= (state_next == FWW_INIT);
			config_mismatch_flag_o <= (state_reg == FWW_NORMAL) && pair_bad;
			err_at_limit_o         <= (err_reg >= err_lim);
			refresh_good_o         <= good_ev;
			refresh_bad_o          <= bad_ev;
		end
	end

	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			rd_data_o <= 16'h0000;
		else if (rd_i)
		begin
			rd_data_o <= 16'h0000;
			unique case (addr_i)
				REG_STATUS:
				begin
					rd_data_o[ST_INIT_BIT]      <= init_phase_o;
					rd_data_o[ST_CORR_BIT]      <= config_mismatch_flag_o;
					rd_data_o[ST_DIS_BIT]       <= disabled_reg;
					rd_data_o[ST_ERRC_LSB +: 4] <= err_reg;
					rd_data_o[ST_RFRC_LSB +: 3] <= rfr_reg;
				end
				REG_SAFETY_IO: rd_data_o[SAFE_CHAL_BIT] <= chal_reg;
				REG_WINDOW:
				begin
					rd_data_o[WIN_PER_LSB +: 4]  <= period_reg;
					rd_data_o[WIN_DUTY_LSB +: 3] <= duty_reg;
				end
				REG_SEED:      rd_data_o <= seed_reg;
				REG_WDCFG:
				begin
					rd_data_o[3:0]               <= wdcfg_reg;
					rd_data_o[CFG_ERRC_LSB +: 4] <= err_reg;
					rd_data_o[CFG_RFRC_LSB +: 3] <= rfr_reg;
				end
				REG_WDCFG_NOT: rd_data_o[3:0] <= wdcfg_not_reg;
				default:       rd_data_o <= 16'h0000;
			endcase
		end
	end

	// ==========================================================
	// Checks.
	init_entry_a: assert property (!released_reg |=> state_reg == FWW_INIT)
		else $error("not in initialization while reset output held");
	mismatch_off_a: assert property (state_reg == FWW_INIT |=> !config_mismatch_flag_o)
		else $error("corruption flag raised during initialization");
	mismatch_set_a: assert property (state_reg == FWW_NORMAL && pair_bad && $stable(wdcfg_reg)
		|=> config_mismatch_flag_o)
		else $error("complement mismatch not flagged");
	goto_init_a: assert property (goto_ev && released_reg |=> state_reg == FWW_INIT && init_phase_o)
		else $error("return request did not re-enter initialization");
	err_add_a: assert property (bad_ev |=> err_reg == (($past(err_reg) + 4'h2 > err_lim) ? err_lim
		: $past(err_reg) + 4'h2))
		else $error("error counter did not add two");
	rfr_clear_a: assert property (bad_ev |=> rfr_reg == 3'h0 && refresh_bad_o)
		else $error("refresh counter not cleared by bad refresh");
	window_restart_a: assert property ((good_ev || bad_ev) |=> win_cnt_reg == 32'h0)
		else $error("window did not restart after refresh");
	closed_bad_a: assert property (state_reg == FWW_NORMAL && ans_wr && !in_open && !goto_ev
		&& released_reg && !disabled_reg |-> bad_ev && !good_ev)
		else $error("answer in closed portion not judged bad");
	seed_reject_a: assert property (wr_i && addr_i == REG_SEED && !chal_reg && wr_data_i == SEED_ONES
		|=> comm_error_o && $stable(seed_reg))
		else $error("illegal seed accepted");
	lfsr_hold_a: assert property (chal_reg && bad_ev && !(wr_i && addr_i == REG_SEED)
		|=> $stable(seed_reg))
		else $error("challenge changed on wrong answer");
endmodule : fww_watchdog

/* File: fww_mcu_model.sv */
// Bus master model of the supervising controller: register writes, reads, protected pairs, answers.
// Assumes the watchdog samples both strobes on the rising edge of clock_i and never stalls.
`timescale 1ns/1ns
module fww_mcu_model
	import fww_pkg::*;
(
	// Clock.
	input  wire logic                        clock_i,
	// Register bus.
	output logic      [fww_pkg::ADDR_W-1:0]  addr_o,
	output logic      [fww_pkg::DATA_W-1:0]  wr_data_o,
	output logic                             wr_o,
	output logic                             rd_o,
	input  wire logic [fww_pkg::DATA_W-1:0]  rd_data_i
);
	initial
	begin
		addr_o    = 8'h00;
		wr_data_o = 16'h0000;
		wr_o      = 1'b0;
		rd_o      = 1'b0;
	end
	// ==========================================================
	// Bus cycles
	// Idle lines show the inverse of the last value so that stale data never looks valid.
	task automatic write_reg(input logic [7:0] a, input logic [15:0] v);
		@(posedge clock_i);
		addr_o    <= a;
		wr_data_o <= v;
		wr_o      <= 1'b1;
		@(posedge clock_i);
		wr_o      <= 1'b0;
		addr_o    <= ~a;
		wr_data_o <= ~v;
		#1;
	endtask : write_reg
	task automatic read_reg(input logic [7:0] a, output logic [15:0] v);
		@(posedge clock_i);
		addr_o <= a;
		rd_o   <= 1'b1;
		@(posedge clock_i);
		rd_o   <= 1'b0;
		addr_o <= ~a;
		#1;
		v = rd_data_i;
	endtask : read_reg
	// ==========================================================
	// Protocol steps
	// Value first, then its complement; reserved bits are sent as zero.
	task automatic write_pair(input logic [7:0] a, input logic [7:0] a_not, input logic [3:0] v);
		write_reg(a, {12'h000, v});
		write_reg(a_not, {12'h000, ~v});
	endtask : write_pair
	task automatic answer(input logic [15:0] v);
		write_reg(REG_ANSWER, v);
	endtask : answer
endmodule : fww_mcu_model

/* File: failsafe_window_watchdog_tb.sv */
// Self-checking bench for the fail-safe window watchdog: hand-written initialization cases, a table of duty cases, then further hand-written cases.
// Assumes the controller model drives the register bus; one millisecond is shortened to eight cycles.
`timescale 1ns/1ns
module failsafe_window_watchdog_tb;
	import fww_pkg::*;
	typedef struct { logic [2:0] duty; int closed; } fww_row_t;
	// ==========================================================
	// Signals
	logic        clock_i;
	logic        reset_n_i;
	logic        rst_out_n;
	logic [1:0]  tmo_sel;
	logic [7:0]  addr;
	logic [15:0] wdata;
	logic        wr;
	logic        rd;
	logic [15:0] rdata;
	logic        init_ph;
	logic        mism;
	logic        at_lim;
	logic        good;
	logic        bad;
	logic        fdec;
	logic        cerr;
	logic [15:0] d;
	logic [15:0] seed;
	logic        seen;
	int          n;
	int          err_total;
	int          num_checks;
	logic [15:0] rej [2]     = '{SEED_ZERO, SEED_ONES};
	fww_row_t    rows [8]    = '{'{3'h0, 10}, '{3'h1, 12}, '{3'h2, 16}, '{3'h3, 20},
	                             '{3'h4, 22}, '{3'h5, 16}, '{3'h6, 16}, '{3'h7, 16}};
	logic [23:0] rst_tab [8] = '{{REG_STATUS, 16'h0001}, {REG_SAFETY_IO, 16'h0000}, {REG_WINDOW, 16'h0023},
	                             {REG_SEED, SEED_RST}, {REG_ANSWER, 16'h0000}, {REG_WDCFG, 16'h0001},
	                             {REG_WDCFG_NOT, 16'h000E}, {8'h1C, 16'h0000}};
	// ==========================================================
	// Design and controller model
	fww_watchdog #(.CYCLES_PER_MS(8)) DUT (
		.clock_i               (clock_i),
		.reset_n_i             (reset_n_i),
		.reset_output_n_i      (rst_out_n),
		.init_timeout_select_i (tmo_sel),
		.addr_i                (addr),
		.wr_data_i             (wdata),
		.wr_i                  (wr),
		.rd_i                  (rd),
		.rd_data_o             (rdata),
		.init_phase_o          (init_ph),
		.config_mismatch_flag_o(mism),
		.err_at_limit_o        (at_lim),
		.refresh_good_o        (good),
		.refresh_bad_o         (bad),
		.fault_decrement_o     (fdec),
		.comm_error_o          (cerr)
	);
	fww_mcu_model mcu (
		.clock_i  (clock_i),
		.addr_o   (addr),
		.wr_data_o(wdata),
		.wr_o     (wr),
		.rd_o     (rd),
		.rd_data_i(rdata)
	);
	initial
	begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end
	// ==========================================================
	// Helpers
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], ^(s & LFSR_TAPS)};
	endfunction : lfsr_next
	task automatic test_done;
		$display("checks %0d, mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
		logic [15:0] v;
		mcu.read_reg(a, v);
		chk(v, exp);
	endtask : rd_chk
	// The expected pair is {good, bad}, seen in the cycle after the judging edge.
	task automatic ans_chk(input logic [15:0] v, input logic [1:0] exp);
		mcu.answer(v);
		chk({14'h0000, good, bad}, {14'h0000, exp});
	endtask : ans_chk
	task automatic tick(input int k);
		repeat (k) @(posedge clock_i);
	endtask : tick
	task automatic wait_bad(output int k);
		k = 0;
		do
		begin
			@(posedge clock_i);
			#1;
			k++;
		end
		while (bad !== 1'b1 && k < 5000);
		if (k >= 5000)
		begin
			err_total++;
			test_done();
		end
	endtask : wait_bad
	initial
	begin
		#80000;
		err_total++;
		test_done();
	end
	// ==========================================================
	// Main sequence
	initial
	begin
		err_total  = 0;
		num_checks = 0;
		reset_n_i  = 1'b0;
		rst_out_n  = 1'b0;
		tmo_sel    = 2'b00;
		tick(10);
		reset_n_i <= 1'b1;
		tick(1);
		rst_out_n <= 1'b1;
		tick(6);
		#1 chk(16'(init_ph), 16'h0001);
		foreach (rej[i])
		begin
			mcu.write_reg(REG_SEED, rej[i]);
			chk(16'(cerr), 16'h0001);
		end
		rd_chk(REG_SEED, SEED_RST);
		mcu.write_pair(REG_WDCFG, REG_WDCFG_NOT, 4'hE);
		rd_chk(REG_WDCFG, 16'h000E);
		ans_chk(SEED_RST, 2'b10);
		chk(16'(init_ph), 16'h0000);
		rd_chk(REG_STATUS, 16'h0100);
		$display("test init done");
		// Each row: switch duty, restart by a wrong answer, then answer early and in time.
		foreach (rows[i])
		begin
			mcu.write_reg(REG_WINDOW, {9'h000, rows[i].duty, 4'h4});
			ans_chk(16'h1234, 2'b01);
			tick(rows[i].closed - 4);
			ans_chk(SEED_RST, 2'b01);
			tick(rows[i].closed);
			ans_chk(SEED_RST, 2'b10);
		end
		$display("test duty table done");
		mcu.write_reg(REG_WINDOW, 16'h0021);
		wait_bad(n);
		chk(16'(n > 25 && n < 33), 16'h0001);
		wait_bad(n);
		chk(16'(n > 5 && n < 10), 16'h0001);
		rd_chk(REG_STATUS, 16'h0040);
		chk(16'(at_lim), 16'h0001);
		tick(1);
		ans_chk(SEED_RST, 2'b10);
		rd_chk(REG_WDCFG, 16'h130E);
		tick(2);
		tmo_sel <= 2'b01;
		ans_chk(SEED_RST, 2'b10);
		chk(16'(fdec), 16'h0001);
		rd_chk(REG_STATUS, 16'h0020);
		mcu.write_reg(REG_SAFETY_IO, 16'h0001);
		chk(16'(init_ph), 16'h0001);
		$display("test counters done");
		wait_bad(n);
		chk(16'(n > 4088 && n < 4104), 16'h0001);
		chk(16'(init_ph), 16'h0001);
		mcu.write_reg(REG_WDCFG_NOT, 16'h0000);
		mcu.write_reg(REG_WINDOW, 16'h0020);
		mcu.write_reg(REG_SAFETY_IO, 16'h0002);
		ans_chk(SEED_RST, 2'b01);
		rd_chk(REG_SEED, SEED_RST);
		chk(16'(mism), 16'h0000);
		ans_chk(~SEED_RST, 2'b10);
		seed = lfsr_next(SEED_RST);
		tick(1);
		#1 chk(16'(mism), 16'h0001);
		rd_chk(REG_SEED, seed);
		mcu.read_reg(REG_STATUS, d);
		chk(d & 16'h0007, 16'h0006);
		mcu.write_reg(REG_SEED, 16'h1111);
		rd_chk(REG_SEED, seed);
		mcu.write_reg(REG_WDCFG, 16'h0000);
		mcu.read_reg(REG_WDCFG, d);
		chk(d & 16'h000F, 16'h000E);
		seen = 1'b0;
		repeat (200)
		begin
			tick(1);
			#1 seen = seen | (bad === 1'b1);
		end
		chk(16'(seen), 16'h0000);
		mcu.write_reg(REG_SAFETY_IO, 16'h0001);
		mcu.write_reg(REG_WDCFG_NOT, 16'hFFF1);
		ans_chk(~seed, 2'b10);
		tick(1);
		#1 chk(16'(mism), 16'h0000);
		$display("test challenger done");
		reset_n_i <= 1'b0;
		tick(1);
		#1 chk(16'(init_ph), 16'h0001);
		tick(9);
		reset_n_i <= 1'b1;
		foreach (rst_tab[i])
			rd_chk(rst_tab[i][23:16], rst_tab[i][15:0]);
		$display("test reset done");
		test_done();
	end
endmodule : failsafe_window_watchdog_tb
